/* File: inc/nvm_regs_cfg.svh */
// constant definitions for the nvm clock, security and index register bank
`ifndef NVM_REGS_CFG_SVH
`define NVM_REGS_CFG_SVH

// ***************************************************************
// register indices (byte address = index * 4)
// ***************************************************************
`define CLKDIV_IDX 16'h3020
`define SEC_COPY_IDX 16'h3021
`define WORD_INDEX_IDX 16'h3022
`define CMD_HI_IDX 16'h302A
`define CMD_LO_IDX 16'h302B

// ***************************************************************
// field positions
// ***************************************************************
`define DIV_WRITTEN_BIT 7
`define DIV_LOCK_BIT 6
`define DIVISOR_MSB 5
`define KEY_MSB 7
`define KEY_LSB 6
`define SEC_MSB 1
`define SEC_LSB 0
`define INDEX_MSB 2

// ***************************************************************
// reset values and encodings
// ***************************************************************
`define CLKDIV_RESET 8'h00
`define WORD_INDEX_RESET 3'h0
`define SEC_COPY_RESET 8'h00
`define KEY_ENABLED 2'h2
`define SEC_UNSECURED 2'h2
`define SEC_BYTE_ADDR 16'hFF7F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: inc/nvm_regs_pkg.sv */
// types shared by the nvm register bank files
package nvm_regs_pkg;
    // security byte loader sequence
    typedef enum logic [1:0] {
        LD_REQ = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } load_state_t;
    // axi response code
    typedef logic [1:0] axi_resp_t;
endpackage : nvm_regs_pkg

/* File: hw/security_byte_loader.sv */
// fetches the stored security byte from flash once after reset
`timescale 1ns/1ps
`include "nvm_regs_cfg.svh"
module security_byte_loader
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // flash read port
    output logic flash_rd_req,
    output logic [15:0] flash_rd_addr,
    input wire logic [7:0] flash_rd_data,
    input wire logic flash_rd_valid,
    // loaded copy
    output logic [7:0] sec_byte,
    output logic load_done
);
    // ***************************************************************
    // load sequence
    // ***************************************************************
    nvm_regs_pkg::load_state_t state_reg; // loader state
    wire take_w = (state_reg == nvm_regs_pkg::LD_WAIT) && flash_rd_valid;

    // request is raised from release of reset until the byte returns
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= nvm_regs_pkg::LD_REQ;
            flash_rd_req <= 1'b0;
            flash_rd_addr <= 16'h0000;
            sec_byte <= `SEC_COPY_RESET;
            load_done <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                nvm_regs_pkg::LD_REQ:
                begin
                    state_reg <= nvm_regs_pkg::LD_WAIT;
                    flash_rd_req <= 1'b1;
                    flash_rd_addr <= `SEC_BYTE_ADDR;
                end
                nvm_regs_pkg::LD_WAIT:
                begin
                    // capture only once: later reads cannot alter the copy
                    if (take_w)
                    begin
                        state_reg <= nvm_regs_pkg::LD_DONE;
                        flash_rd_req <= 1'b0;
                        sec_byte <= flash_rd_data;
                        load_done <= 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= nvm_regs_pkg::LD_DONE;
                end
            endcase
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    AST_SEC_LOADED_FROM_FLASH:
        assert property (@(posedge aclk) disable iff (!aresetn)
            take_w |=> (sec_byte == $past(flash_rd_data)) && load_done)
        else $error("security copy not loaded from flash byte");
endmodule : security_byte_loader

/* File: hw/program_timebase.sv */
// divides the bus clock by divisor+1 into a timebase tick
`timescale 1ns/1ps
module program_timebase
#(
    parameter int DIV_W = 6
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // divider setting
    input wire logic enable,
    input wire logic [DIV_W-1:0] divisor,
    // timebase
    output logic tick
);
    initial
    begin
        if (DIV_W < 1 || DIV_W > 16)
        begin
            $error("program_timebase: DIV_W out of range");
        end
    end

    // ***************************************************************
    // tick counter
    // ***************************************************************
    logic [DIV_W-1:0] count_reg; // cycles since last tick
    wire wrap_w = (count_reg >= divisor);

    // runs only once the divider has been loaded; a divisor written
    // mid-count takes effect at the next wrap at latest
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            count_reg <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count_reg <= wrap_w ? '0 : count_reg + 1'b1;
            tick <= wrap_w;
        end
    end
endmodule : program_timebase

/* File: hw/nvm_clock_security_index_regs.sv */
// axi4-lite register bank: clock divider, security copy and command index
`timescale 1ns/1ps
`include "nvm_regs_cfg.svh"
// Function
// - bit 7 shows divider written since reset
// - lock bit freezes divisor until reset
// - security copy readable, writes ignored
// - security copy loaded from flash 0xFF7F
// - backdoor enabled only for value 10
// - unsecured only for state value 10
// - backdoor unlock forces state to 10
// - index bits 7 to 3 read zero
// - index selects command object word
// - index at launch gives word count
// - divider and index reset to 00h
module nvm_clock_security_index_regs
#(
    parameter int ADDR_W = 16,
    parameter int WORDS = 8
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // flash read port for the security byte
    output logic flash_rd_req,
    output logic [15:0] flash_rd_addr,
    input wire logic [7:0] flash_rd_data,
    input wire logic flash_rd_valid,
    // command sequencer side
    input wire logic command_done_flag,
    input wire logic cmd_launch,
    input wire logic [2:0] cmd_rd_index,
    output logic [15:0] cmd_rd_word,
    output logic [2:0] launch_index,
    input wire logic backdoor_unlocked,
    // security and timebase outputs
    output logic backdoor_allowed,
    output logic device_secured,
    output logic divider_written_flag,
    output logic timebase_tick
);
    // ***************************************************************
    // elaboration checks
    // ***************************************************************
    initial
    begin
        if (ADDR_W < 16 || ADDR_W > 32)
        begin
            $error("ADDR_W must lie between 16 and 32");
        end
        if (WORDS != 8)
        begin
            $error("WORDS must be 8 for a three-bit index");
        end
    end

    // word addresses of the registers
    localparam logic [ADDR_W-3:0] CLKDIV_A = (ADDR_W-2)'(`CLKDIV_IDX);
    localparam logic [ADDR_W-3:0] SEC_A = (ADDR_W-2)'(`SEC_COPY_IDX);
    localparam logic [ADDR_W-3:0] INDEX_A = (ADDR_W-2)'(`WORD_INDEX_IDX);
    localparam logic [ADDR_W-3:0] HI_A = (ADDR_W-2)'(`CMD_HI_IDX);
    localparam logic [ADDR_W-3:0] LO_A = (ADDR_W-2)'(`CMD_LO_IDX);

    // ***************************************************************
    // register state
    // ***************************************************************
    logic written_reg; // divider written since reset
    logic lock_reg; // divisor frozen
    logic [`DIVISOR_MSB:0] divisor_reg; // clock divisor field
    logic [`INDEX_MSB:0] index_reg; // command word index field
    logic [15:0] cmd_array [WORDS]; // command object words
    logic forced_reg; // unsecured by backdoor key
    logic [7:0] sec_byte_w; // byte from the loader
    logic load_done_w; // loader finished

    // ***************************************************************
    // axi write channel
    // ***************************************************************
    logic aw_held_reg; // write address captured
    logic w_held_reg; // write data captured
    logic [ADDR_W-3:0] aw_word_reg; // captured word address
    logic [7:0] w_byte_reg; // captured low byte
    logic w_lane0_reg; // low byte lane enabled
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    nvm_regs_pkg::axi_resp_t bresp_reg;

    // handshakes and write decode
    wire aw_fire = awvalid && awready_reg;
    wire w_fire = wvalid && wready_reg;
    wire wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_en = wr_do && w_lane0_reg;
    wire wr_clkdiv = (aw_word_reg == CLKDIV_A);
    wire wr_sec = (aw_word_reg == SEC_A);
    wire wr_index = (aw_word_reg == INDEX_A);
    wire wr_hi = (aw_word_reg == HI_A);
    wire wr_lo = (aw_word_reg == LO_A);
    wire wr_hit = wr_clkdiv || wr_sec || wr_index || wr_hi || wr_lo;
    // a divider write during a command is dropped rather than corrupting
    // the timers of the running operation
    wire div_wr = wr_en && wr_clkdiv && command_done_flag;
    wire aw_held_next = (aw_held_reg || aw_fire) && !wr_do;
    wire w_held_next = (w_held_reg || w_fire) && !wr_do;
    wire bvalid_next = wr_do || (bvalid_reg && !bready);

    // capture address and data in either order, answer after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_word_reg <= '0;
            w_byte_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= !aw_held_next && !bvalid_next;
            wready_reg <= !w_held_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
            if (aw_fire)
            begin
                aw_word_reg <= awaddr[ADDR_W-1:2];
            end
            if (w_fire)
            begin
                w_byte_reg <= wdata[7:0];
                w_lane0_reg <= wstrb[0];
            end
            // unmapped write answers with slave error
            if (wr_do)
            begin
                bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ***************************************************************
    // divider, index and security state
    // ***************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            written_reg <= 1'b0;
            lock_reg <= 1'b0;
            divisor_reg <= '0;
            index_reg <= `WORD_INDEX_RESET;
            forced_reg <= 1'b0;
        end
        else
        begin
            // any accepted write marks the register loaded
            if (div_wr)
            begin
                written_reg <= 1'b1;
            end
            // lock only sets; it clears by reset alone
            if (div_wr && !lock_reg)
            begin
                lock_reg <= w_byte_reg[`DIV_LOCK_BIT];
                divisor_reg <= w_byte_reg[`DIVISOR_MSB:0];
            end
            if (wr_en && wr_index)
            begin
                index_reg <= w_byte_reg[`INDEX_MSB:0];
            end
            // sticky until reset; event outranks nothing that clears it
            if (backdoor_unlocked)
            begin
                forced_reg <= 1'b1;
            end
        end
    end

    // ***************************************************************
    // command object array
    // ***************************************************************
    // hi and lo bytes of the word picked by the index
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                cmd_array[i] <= 16'h0000;
            end
        end
        else if (wr_en && wr_hi)
        begin
            cmd_array[index_reg][15:8] <= w_byte_reg;
        end
        else if (wr_en && wr_lo)
        begin
            cmd_array[index_reg][7:0] <= w_byte_reg;
        end
    end

    // ***************************************************************
    // read data decode
    // ***************************************************************
    wire [ADDR_W-3:0] ar_word = araddr[ADDR_W-1:2];
    wire [7:0] clkdiv_read = {written_reg, lock_reg, divisor_reg};
    // reserved bits pass through as loaded; the copy has no write path
    wire [1:0] sec_state = forced_reg ? `SEC_UNSECURED : sec_byte_w[`SEC_MSB:`SEC_LSB];
    wire [7:0] sec_read = {sec_byte_w[7:2], sec_state};
    wire [7:0] index_read = {5'h00, index_reg};
    wire [15:0] cur_word = cmd_array[index_reg];
    wire rd_hit = (ar_word == CLKDIV_A) || (ar_word == SEC_A) || (ar_word == INDEX_A)
        || (ar_word == HI_A) || (ar_word == LO_A);
    wire [7:0] rd_byte = (ar_word == CLKDIV_A) ? clkdiv_read :
        (ar_word == SEC_A) ? sec_read :
        (ar_word == INDEX_A) ? index_read :
        (ar_word == HI_A) ? cur_word[15:8] :
        (ar_word == LO_A) ? cur_word[7:0] : 8'h00;

    // ***************************************************************
    // axi read channel
    // ***************************************************************
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    nvm_regs_pkg::axi_resp_t rresp_reg;
    wire ar_fire = arvalid && arready_reg;
    wire rvalid_next = ar_fire || (rvalid_reg && !rready);

    // one read in flight; data held until rready
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_OKAY;
        end
        else
        begin
            arready_reg <= !rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_fire)
            begin
                rdata_reg <= {24'h000000, rd_byte};
                rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ***************************************************************
    // sequencer and security outputs
    // ***************************************************************
    logic [15:0] cmd_rd_word_reg;
    logic [2:0] launch_index_reg;
    logic key_reg;
    logic secured_reg;

    // registered copies so every output leaves a flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmd_rd_word_reg <= 16'h0000;
            launch_index_reg <= 3'h0;
            key_reg <= 1'b0;
            secured_reg <= 1'b1;
        end
        else
        begin
            cmd_rd_word_reg <= cmd_array[cmd_rd_index];
            // launch follows the done flag being cleared by software
            if (cmd_launch)
            begin
                launch_index_reg <= index_reg;
            end
            key_reg <= load_done_w && (sec_read[`KEY_MSB:`KEY_LSB] == `KEY_ENABLED);
            secured_reg <= (sec_state != `SEC_UNSECURED);
        end
    end

    // ***************************************************************
    // sub-blocks
    // ***************************************************************
    security_byte_loader security_byte_loader_i
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr),
        .flash_rd_data(flash_rd_data),
        .flash_rd_valid(flash_rd_valid),
        .sec_byte(sec_byte_w),
        .load_done(load_done_w)
    );

    program_timebase #(.DIV_W(`DIVISOR_MSB + 1)) program_timebase_i
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(written_reg),
        .divisor(divisor_reg),
        .tick(timebase_tick)
    );

    // port drives
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign cmd_rd_word = cmd_rd_word_reg;
    assign launch_index = launch_index_reg;
    assign backdoor_allowed = key_reg;
    assign device_secured = secured_reg;
    assign divider_written_flag = written_reg;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_BUSY_DROPS_DIVIDER:
        assert property (wr_en && wr_clkdiv && !command_done_flag
            |=> $stable(clkdiv_read))
        else $error("divider changed by write during command");
    AST_WRITTEN_SETS:
        assert property (div_wr |=> written_reg ##1 written_reg)
        else $error("written flag not set after divider write");
    AST_WRITTEN_CAUSE:
        assert property ($rose(written_reg) |-> $past(div_wr))
        else $error("written flag rose without a write");
    AST_LOCK_FREEZES:
        assert property (lock_reg |=> lock_reg && $stable(divisor_reg))
        else $error("locked divisor or lock bit changed");
    AST_SEC_IGNORES_WRITE:
        assert property (wr_en && wr_sec && load_done_w && !backdoor_unlocked
            |=> $stable(sec_read))
        else $error("security copy changed by a write");
    AST_KEY_DECODE:
        assert property (load_done_w |=> key_reg == ($past(sec_read[7:6]) == 2'h2))
        else $error("backdoor enable decode wrong");
    AST_SECURED_DECODE:
        assert property (1'b1 |=> secured_reg == ($past(sec_state) != 2'h2))
        else $error("secured state decode wrong");
    AST_FORCED_UNSECURE:
        assert property (backdoor_unlocked |-> ##2 !secured_reg && sec_read[1:0] == 2'h2)
        else $error("backdoor unlock did not force unsecured");
    AST_INDEX_UPPER_ZERO:
        assert property (ar_fire && ar_word == INDEX_A |=> rdata_reg[7:3] == 5'h00)
        else $error("index reserved bits not zero");
    AST_ARRAY_HI_WRITE:
        assert property (wr_en && wr_hi
            |=> cmd_array[$past(index_reg)][15:8] == $past(w_byte_reg))
        else $error("command word high byte not written");
    AST_LAUNCH_INDEX:
        assert property (cmd_launch |=> launch_index_reg == $past(index_reg))
        else $error("launch index not captured");
    AST_RESET_ZERO:
        assert property (!$past(aresetn) |-> clkdiv_read == 8'h00 && index_reg == 3'h0)
        else $error("divider or index not zero after reset");

    COV_LOCKED_WRITE: cover property (lock_reg && div_wr);
    COV_SEC_READ: cover property (ar_fire && ar_word == SEC_A);
    COV_LAUNCH: cover property (cmd_launch && index_reg == 3'h5);
    COV_UNLOCK: cover property (backdoor_unlocked);
endmodule : nvm_clock_security_index_regs

/* File: verification/nvm_clock_security_index_regs_tb.sv */
// self-checking bench for the nvm clock, security and index register bank
`timescale 1ns/1ps
`include "nvm_regs_cfg.svh"
module nvm_clock_security_index_regs_tb;
    // ***************************************************************
    // signals
    // ***************************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    // protection codes are not exercised
    logic [2:0] awprot = 3'h0, arprot = 3'h0, cmd_rd_index = 3'h0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic [7:0] flash_rd_data = 8'h00;
    logic flash_rd_valid = 1'b0, command_done_flag = 1'b1, cmd_launch = 1'b0;
    logic backdoor_unlocked = 1'b0, loaded = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, flash_rd_req, backdoor_allowed;
    logic device_secured, divider_written_flag, timebase_tick;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] flash_rd_addr, cmd_rd_word;
    logic [2:0] launch_index;
    logic [1:0] bq[$]; // expected write responses, oldest first
    logic [33:0] rq[$]; // expected {rresp, rdata}, oldest first
    int n_fail = 0, checks_done = 0, n;
    integer seed = 32'h99e9289b;
    logic [7:0] sb, hv[8], lv[8]; // stored security byte, command words
    logic [5:0] dv;
    localparam logic [15:0] A_DIV = 16'(`CLKDIV_IDX * 4);
    localparam logic [15:0] A_SEC = 16'(`SEC_COPY_IDX * 4);
    localparam logic [15:0] A_IDX = 16'(`WORD_INDEX_IDX * 4);
    localparam logic [15:0] A_HI = 16'(`CMD_HI_IDX * 4);
    localparam logic [15:0] A_LO = 16'(`CMD_LO_IDX * 4);

    always #2 aclk = ~aclk;

    nvm_clock_security_index_regs nvm_clock_security_index_regs_i
    (
        .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .flash_rd_req, .flash_rd_addr, .flash_rd_data,
        .flash_rd_valid, .command_done_flag, .cmd_launch, .cmd_rd_index, .cmd_rd_word,
        .launch_index, .backdoor_unlocked, .backdoor_allowed, .device_secured,
        .divider_written_flag, .timebase_tick
    );

    // ***************************************************************
    // checking and closing
    // ***************************************************************
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // a wait that ran out of cycles ends the run
    task automatic tmo(input int k);
        if (k >= 200)
        begin
            n_fail++;
            close_out();
        end
    endtask : tmo

    // ***************************************************************
    // axi4-lite master
    // ***************************************************************
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] e);
        int k;
        k = 0;
        @(posedge aclk);
        bq.push_back(e);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end
        while (!bvalid && k < 200);
        bready <= 1'b0;
        tmo(k);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [33:0] e);
        int k;
        k = 0;
        @(posedge aclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            arvalid <= arvalid && !arready;
        end
        while (!rvalid && k < 200);
        rready <= 1'b0;
        tmo(k);
    endtask : rd

    // watcher: each answer taken is matched to the oldest note
    always @(posedge aclk)
    begin
        if (bvalid && bready)
            chk("bresp", {32'h00000000, bq.pop_front()}, {32'h00000000, bresp});
        if (rvalid && rready)
            chk("read", rq.pop_front(), {rresp, rdata});
    end

    // flash answers a request one cycle late; idle data keeps changing
    always @(posedge aclk)
    begin
        flash_rd_valid <= flash_rd_req && aresetn;
        flash_rd_data <= flash_rd_req ? sb : 8'($random(seed));
        if (flash_rd_req && flash_rd_valid)
            loaded <= 1'b1;
    end

    // reset for 8 cycles, then wait for the security byte to arrive
    task automatic rst;
        @(posedge aclk);
        aresetn <= 1'b0;
        loaded <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        n = 0;
        while (!loaded && n < 200)
        begin
            @(posedge aclk);
            n++;
            if (flash_rd_req)
                chk("flash addr", `SEC_BYTE_ADDR, flash_rd_addr);
        end
        tmo(n);
        repeat (2) @(posedge aclk);
    endtask : rst

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial
    begin
        // every key and state code, once each
        for (int k = 0; k < 4; k++)
        begin
            sb = {k[1:0], 4'($random(seed)), k[1:0]};
            rst();
            chk("allowed", k == 2, backdoor_allowed);
            chk("secured", k != 2, device_secured);
            rd(A_SEC, {26'h0, sb});
            wr(A_SEC, ~sb, 4'hF, 2'h0);
            rd(A_SEC, {26'h0, sb});
            backdoor_unlocked <= 1'b1;
            @(posedge aclk);
            backdoor_unlocked <= 1'b0;
            repeat (3) @(posedge aclk);
            chk("unlocked", 34'h0, device_secured);
            rd(A_SEC, {26'h0, sb[7:2], 2'h2});
        end
        // divider: busy refusal, written flag, timebase, lock
        command_done_flag <= 1'b0;
        wr(A_DIV, 8'h05, 4'hF, 2'h0);
        command_done_flag <= 1'b1;
        rd(A_DIV, 34'h0);
        dv = 6'($random(seed));
        wr(A_DIV, {2'h0, dv}, 4'hF, 2'h0);
        rd(A_DIV, {26'h0, 2'h2, dv});
        chk("written", 34'h1, divider_written_flag);
        n = 0;
        repeat (6 * (dv + 1)) @(posedge aclk) n += timebase_tick;
        chk("ticks", 34'h6, 34'(n));
        wr(A_DIV, {2'h1, dv}, 4'hF, 2'h0);
        wr(A_DIV, {2'h0, ~dv}, 4'hF, 2'h0);
        rd(A_DIV, {26'h0, 2'h3, dv});
        // index: upper bits read zero, masked lane ignored
        wr(A_IDX, 8'hFF, 4'hF, 2'h0);
        wr(A_IDX, 8'h02, 4'h0, 2'h0);
        rd(A_IDX, 34'h7);
        for (int i = 0; i < 8; i++)
        begin
            hv[i] = 8'($random(seed));
            lv[i] = 8'($random(seed));
            wr(A_IDX, 8'(i), 4'hF, 2'h0);
            wr(A_HI, hv[i], 4'hF, 2'h0);
            wr(A_LO, lv[i], 4'hF, 2'h0);
        end
        // read back in reverse so a stuck index shows
        for (int i = 7; i >= 0; i--)
        begin
            cmd_rd_index <= 3'(i);
            wr(A_IDX, 8'(i), 4'hF, 2'h0);
            rd(A_HI, {26'h0, hv[i]});
            rd(A_LO, {26'h0, lv[i]});
            chk("cmd word", {18'h0, hv[i], lv[i]}, cmd_rd_word);
        end
        wr(A_IDX, 8'h05, 4'hF, 2'h0);
        cmd_launch <= 1'b1;
        @(posedge aclk);
        cmd_launch <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("launch index", 34'h5, launch_index);
        wr(16'hC090, 8'h5A, 4'hF, 2'h2);
        rd(16'hC090, {2'h2, 32'h0});
        // a second reset clears values and the lock
        rst();
        rd(A_DIV, 34'h0);
        rd(A_IDX, 34'h0);
        wr(A_DIV, {2'h0, ~dv}, 4'hF, 2'h0);
        rd(A_DIV, {26'h0, 2'h2, ~dv});
        repeat (4) @(posedge aclk);
        close_out();
    end
endmodule : nvm_clock_security_index_regs_tb
